// ==== hdl/mca_pkg.sv ====
// constants and carrier types shared by the circular addressing block
// What this block does
// - one circular buffer in X, one in Y
// - X buffer also serves program space pointers
// - working registers 0 to 14 may be the pointer; select 15 turns the buffer off
// - start and end held in 16-bit registers
// - length derived from end minus start plus one
// - buffer may span 32K words, 64 Kbytes
// - Y addresses assume words, LSB forced clear
// - X select bits 3:0, enable bit 15
// - Y select bits 7:4, enable bit 14
// - power-of-two buffers checked at both bounds
package mca_pkg;

  // ************************************************************
  // register map, byte addresses on the wishbone port
  // ************************************************************
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_XSTART  = 8'h04;
  localparam logic [7:0]  OFS_XEND    = 8'h08;
  localparam logic [7:0]  OFS_YSTART  = 8'h0C;
  localparam logic [7:0]  OFS_YEND    = 8'h10;
  localparam logic [7:0]  OFS_STATUS  = 8'h14;
  localparam logic [7:0]  OFS_WRAPCNT = 8'h18;

  // ************************************************************
  // control field layout and reset values
  // ************************************************************
  localparam int          XSEL_LSB    = 0;
  localparam int          YSEL_LSB    = 4;
  localparam int          YEN_BIT     = 14;
  localparam int          XEN_BIT     = 15;
  localparam logic [3:0]  SEL_OFF     = 4'hF;
  localparam logic [15:0] RST_CTRL    = 16'h00FF;
  localparam logic [15:0] RST_ADDR    = 16'h0000;
  localparam logic [15:0] RST_CNT     = 16'h0000;

  // ************************************************************
  // status field layout
  // ************************************************************
  localparam int          ST_XRD_WRAP = 0;
  localparam int          ST_XWR_WRAP = 1;
  localparam int          ST_Y_WRAP   = 2;
  localparam int          ST_X_ACT    = 8;
  localparam int          ST_Y_ACT    = 9;

  typedef logic [15:0] mca_word_t;

  // pointer update request from the execution unit
  typedef struct packed {
    logic       valid;
    logic       pspace;
    logic [3:0] wreg;
    mca_word_t  ptr;
    mca_word_t  step;
  } mca_req_s;

  // adjusted pointer returned to the address generator
  typedef struct packed {
    logic       valid;
    logic       pspace;
    logic [3:0] wreg;
    mca_word_t  ptr;
    logic       wrapped;
  } mca_rsp_s;

  // one buffer's configuration
  typedef struct packed {
    logic       en;
    logic [3:0] sel;
    mca_word_t  start;
    mca_word_t  stop;
  } mca_cfg_s;

endpackage

// ==== hdl/mca_breg.sv ====
// one 16-bit software register with byte lane write enables
module mca_breg #(
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        we_in,
  input  wire logic [1:0]  sel_in,
  input  wire logic [15:0] d_in,
  output logic      [15:0] q_out
);

  logic [15:0] val_r;
  logic [15:0] val_nxt;

  // merge only the written byte lanes
  always_comb begin
    val_nxt = val_r;
    if (we_in && sel_in[0]) begin
      val_nxt[7:0] = d_in[7:0];
    end
    if (we_in && sel_in[1]) begin
      val_nxt[15:8] = d_in[15:8];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      val_r <= RST_VAL;
    end else begin
      val_r <= val_nxt;
    end
  end

  assign q_out = val_r;

endmodule

// ==== hdl/mca_wrap.sv ====
// combinational modulo adjust of one pointer update against one buffer
module mca_wrap #(
  parameter bit WORD_ONLY = 1'b0
) (
  input  mca_pkg::mca_cfg_s cfg_in,
  input  mca_pkg::mca_req_s req_in,
  output mca_pkg::mca_rsp_s rsp_out
);

  logic [15:0] base;
  logic [16:0] sum;
  logic [16:0] len;
  logic [16:0] adj;
  logic        act;
  logic        up;
  logic        dn;
  logic        over;
  logic        under;

  // pointer plus signed step, with wrap when the buffer owns the register
  always_comb begin
    base = req_in.ptr;
    if (WORD_ONLY) begin
      base[0] = 1'b0;
    end
    act   = cfg_in.en && (cfg_in.sel != mca_pkg::SEL_OFF)
            && (req_in.wreg == cfg_in.sel);
    sum   = {1'b0, base} + {req_in.step[15], req_in.step};
    // 17 bits so a full 64 Kbyte buffer still has a length
    len   = {1'b0, cfg_in.stop} - {1'b0, cfg_in.start} + 17'h00001;
    up    = !req_in.step[15] && (req_in.step != 16'h0000);
    dn    = req_in.step[15];
    // both bounds always watched, so any direction works
    over  = up && (base <= cfg_in.stop)
            && (sum[16] || (sum[15:0] > cfg_in.stop));
    under = dn && (base >= cfg_in.start)
            && (sum[16] || (sum[15:0] < cfg_in.start));
    adj   = sum;
    if (act && over) begin
      adj = sum - len;
    end else if (act && under) begin
      adj = sum + len;
    end
    rsp_out.valid   = req_in.valid;
    rsp_out.pspace  = req_in.pspace;
    rsp_out.wreg    = req_in.wreg;
    rsp_out.ptr     = adj[15:0];
    rsp_out.wrapped = req_in.valid && act && (over || under);
  end

endmodule

// ==== hdl/mca_top.sv ====
// circular addressing unit: wishbone registers and three pointer adjust channels
//
// The implementer's own choices: register access over Wishbone and the register offsets.
module mca_top (
  input  wire logic              CLK_IN,
  input  wire logic              RST_B_IN,
  // wishbone classic slave
  input  wire logic              WB_CYC_IN,
  input  wire logic              WB_STB_IN,
  input  wire logic              WB_WE_IN,
  input  wire logic [7:0]        WB_ADR_IN,
  input  wire logic [3:0]        WB_SEL_IN,
  input  wire logic [31:0]       WB_DAT_IN,
  output logic      [31:0]       WB_DAT_OUT,
  output logic                   WB_ACK_OUT,
  // pointer update requests
  input  mca_pkg::mca_req_s      XRD_REQ_IN,
  input  mca_pkg::mca_req_s      XWR_REQ_IN,
  input  mca_pkg::mca_req_s      Y_REQ_IN,
  // adjusted pointers
  output mca_pkg::mca_rsp_s      XRD_RSP_OUT,
  output mca_pkg::mca_rsp_s      XWR_RSP_OUT,
  output mca_pkg::mca_rsp_s      Y_RSP_OUT,
  output logic                   X_ACTIVE_OUT,
  output logic                   Y_ACTIVE_OUT
);

  // ************************************************************
  // bus slave
  // ************************************************************

  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic        req_live;
  logic        wr_stb;
  logic [7:0]  adr_w;

  // word aligned decode; the two low address bits are ignored
  assign adr_w    = {WB_ADR_IN[7:2], 2'b00};
  assign req_live = WB_CYC_IN && WB_STB_IN;
  // a write lands on the edge where the master sees ack high
  assign wr_stb   = req_live && WB_WE_IN && ack_r;

  // ************************************************************
  // configuration registers
  // ************************************************************

  logic [15:0] ctrl_q;
  logic [15:0] xstart_q;
  logic [15:0] xend_q;
  logic [15:0] ystart_q;
  logic [15:0] yend_q;

  // only the low two byte lanes carry register bits
  mca_breg #(.RST_VAL(mca_pkg::RST_CTRL)) u_ctrl (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .we_in    (wr_stb && (adr_w == mca_pkg::OFS_CTRL)),
    .sel_in   (WB_SEL_IN[1:0]),
    .d_in     (WB_DAT_IN[15:0]),
    .q_out    (ctrl_q)
  );

  // one start/end pair per space
  mca_breg #(.RST_VAL(mca_pkg::RST_ADDR)) u_xstart (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .we_in    (wr_stb && (adr_w == mca_pkg::OFS_XSTART)),
    .sel_in   (WB_SEL_IN[1:0]),
    .d_in     (WB_DAT_IN[15:0]),
    .q_out    (xstart_q)
  );

  mca_breg #(.RST_VAL(mca_pkg::RST_ADDR)) u_xend (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .we_in    (wr_stb && (adr_w == mca_pkg::OFS_XEND)),
    .sel_in   (WB_SEL_IN[1:0]),
    .d_in     (WB_DAT_IN[15:0]),
    .q_out    (xend_q)
  );

  mca_breg #(.RST_VAL(mca_pkg::RST_ADDR)) u_ystart (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .we_in    (wr_stb && (adr_w == mca_pkg::OFS_YSTART)),
    .sel_in   (WB_SEL_IN[1:0]),
    .d_in     (WB_DAT_IN[15:0]),
    .q_out    (ystart_q)
  );

  mca_breg #(.RST_VAL(mca_pkg::RST_ADDR)) u_yend (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .we_in    (wr_stb && (adr_w == mca_pkg::OFS_YEND)),
    .sel_in   (WB_SEL_IN[1:0]),
    .d_in     (WB_DAT_IN[15:0]),
    .q_out    (yend_q)
  );

  // ************************************************************
  // buffer configurations
  // ************************************************************

  mca_pkg::mca_cfg_s xcfg;
  mca_pkg::mca_cfg_s ycfg;

  // exactly one buffer per space; no third buffer exists
  always_comb begin
    xcfg.en    = ctrl_q[mca_pkg::XEN_BIT];
    xcfg.sel   = ctrl_q[mca_pkg::XSEL_LSB +: 4];
    xcfg.start = xstart_q;
    xcfg.stop  = xend_q;
    ycfg.en    = ctrl_q[mca_pkg::YEN_BIT];
    ycfg.sel   = ctrl_q[mca_pkg::YSEL_LSB +: 4];
    ycfg.start = ystart_q;
    ycfg.stop  = yend_q;
  end

  // ************************************************************
  // pointer adjust channels
  // ************************************************************

  mca_pkg::mca_rsp_s xrd_rsp;
  mca_pkg::mca_rsp_s xwr_rsp;
  mca_pkg::mca_rsp_s y_rsp;

  // the X pair serves data and program space alike
  // read and write generators share the X buffer
  mca_wrap #(.WORD_ONLY(1'b0)) u_xrd (
    .cfg_in  (xcfg),
    .req_in  (XRD_REQ_IN),
    .rsp_out (xrd_rsp)
  );

  mca_wrap #(.WORD_ONLY(1'b0)) u_xwr (
    .cfg_in  (xcfg),
    .req_in  (XWR_REQ_IN),
    .rsp_out (xwr_rsp)
  );

  // Y space works on words only
  mca_wrap #(.WORD_ONLY(1'b1)) u_y (
    .cfg_in  (ycfg),
    .req_in  (Y_REQ_IN),
    .rsp_out (y_rsp)
  );

  // ************************************************************
  // response registers
  // ************************************************************

  mca_pkg::mca_rsp_s xrd_rsp_r;
  mca_pkg::mca_rsp_s xwr_rsp_r;
  mca_pkg::mca_rsp_s y_rsp_r;
  mca_pkg::mca_rsp_s xrd_rsp_nxt;
  mca_pkg::mca_rsp_s xwr_rsp_nxt;
  mca_pkg::mca_rsp_s y_rsp_nxt;
  logic              xact_r;
  logic              yact_r;
  logic              xact_nxt;
  logic              yact_nxt;

  // results are registered once, costing one cycle of latency
  // but keeping the adder chain out of the generator's path
  always_comb begin
    xrd_rsp_nxt = xrd_rsp;
    xwr_rsp_nxt = xwr_rsp;
    y_rsp_nxt   = y_rsp;
    xact_nxt    = xcfg.en && (xcfg.sel != mca_pkg::SEL_OFF);
    yact_nxt    = ycfg.en && (ycfg.sel != mca_pkg::SEL_OFF);
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      xrd_rsp_r <= '0;
      xwr_rsp_r <= '0;
      y_rsp_r   <= '0;
      xact_r    <= 1'b0;
      yact_r    <= 1'b0;
    end else begin
      xrd_rsp_r <= xrd_rsp_nxt;
      xwr_rsp_r <= xwr_rsp_nxt;
      y_rsp_r   <= y_rsp_nxt;
      xact_r    <= xact_nxt;
      yact_r    <= yact_nxt;
    end
  end

  // ************************************************************
  // wrap status and wrap counter
  // ************************************************************

  logic [2:0]  wrap_r;
  logic [2:0]  wrap_nxt;
  logic [2:0]  wrap_set;
  logic [2:0]  wrap_clr;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [1:0]  cnt_inc;

  // sticky flags; a wrap in the clearing cycle is kept
  always_comb begin
    wrap_set = {y_rsp.wrapped, xwr_rsp.wrapped, xrd_rsp.wrapped};
    wrap_clr = '0;
    if (wr_stb && (adr_w == mca_pkg::OFS_STATUS) && WB_SEL_IN[0]) begin
      wrap_clr = WB_DAT_IN[2:0];
    end
    wrap_nxt = (wrap_r & ~wrap_clr) | wrap_set;
  end

  // total wraps seen; any write clears, a same-cycle wrap still counts
  always_comb begin
    cnt_inc = 2'(wrap_set[0]) + 2'(wrap_set[1]) + 2'(wrap_set[2]);
    cnt_nxt = cnt_r;
    if (wr_stb && (adr_w == mca_pkg::OFS_WRAPCNT)) begin
      cnt_nxt = mca_pkg::RST_CNT;
    end
    cnt_nxt = cnt_nxt + 16'(cnt_inc);
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wrap_r <= '0;
      cnt_r  <= mca_pkg::RST_CNT;
    end else begin
      wrap_r <= wrap_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  // ************************************************************
  // bus answer
  // ************************************************************

  // ack one cycle after the request, dropped in the next cycle;
  // unmapped words read zero and ignore writes
  always_comb begin
    ack_nxt  = req_live && !ack_r;
    rdat_nxt = '0;
    if (req_live && !ack_r && !WB_WE_IN) begin
      unique case (adr_w)
        mca_pkg::OFS_CTRL:    rdat_nxt[15:0] = ctrl_q;
        mca_pkg::OFS_XSTART:  rdat_nxt[15:0] = xstart_q;
        mca_pkg::OFS_XEND:    rdat_nxt[15:0] = xend_q;
        mca_pkg::OFS_YSTART:  rdat_nxt[15:0] = ystart_q;
        mca_pkg::OFS_YEND:    rdat_nxt[15:0] = yend_q;
        mca_pkg::OFS_STATUS: begin
          rdat_nxt[mca_pkg::ST_XRD_WRAP] = wrap_r[0];
          rdat_nxt[mca_pkg::ST_XWR_WRAP] = wrap_r[1];
          rdat_nxt[mca_pkg::ST_Y_WRAP]   = wrap_r[2];
          rdat_nxt[mca_pkg::ST_X_ACT]    = xact_r;
          rdat_nxt[mca_pkg::ST_Y_ACT]    = yact_r;
        end
        mca_pkg::OFS_WRAPCNT: rdat_nxt[15:0] = cnt_r;
        default:              rdat_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ack_r  <= 1'b0;
      rdat_r <= '0;
    end else begin
      ack_r  <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // ************************************************************
  // outputs, all straight from flip-flops
  // ************************************************************

  assign WB_ACK_OUT   = ack_r;
  assign WB_DAT_OUT   = rdat_r;
  assign XRD_RSP_OUT  = xrd_rsp_r;
  assign XWR_RSP_OUT  = xwr_rsp_r;
  assign Y_RSP_OUT    = y_rsp_r;
  assign X_ACTIVE_OUT = xact_r;
  assign Y_ACTIVE_OUT = yact_r;

endmodule

// ==== tb/mca_sva.sv ====
// checker: bus handshake, register shadow and pointer adjust properties
module mca_sva (
  input  wire logic         CLK_IN,
  input  wire logic         RST_B_IN,
  input  wire logic         WB_CYC_IN,
  input  wire logic         WB_STB_IN,
  input  wire logic         WB_WE_IN,
  input  wire logic [7:0]   WB_ADR_IN,
  input  wire logic [3:0]   WB_SEL_IN,
  input  wire logic [31:0]  WB_DAT_IN,
  input  wire logic [31:0]  WB_DAT_OUT,
  input  wire logic         WB_ACK_OUT,
  input  mca_pkg::mca_req_s XRD_REQ_IN,
  input  mca_pkg::mca_req_s XWR_REQ_IN,
  input  mca_pkg::mca_req_s Y_REQ_IN,
  input  mca_pkg::mca_rsp_s XRD_RSP_OUT,
  input  mca_pkg::mca_rsp_s XWR_RSP_OUT,
  input  mca_pkg::mca_rsp_s Y_RSP_OUT,
  input  wire logic         X_ACTIVE_OUT,
  input  wire logic         Y_ACTIVE_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // shadow of the five software registers, updated at the ack edge
  // ************************************************************
  logic [15:0]       sh_r   [5];
  logic [15:0]       sh_nxt [5];
  logic              wr;
  logic              x_act;
  logic              y_act;
  mca_pkg::mca_cfg_s xc;
  mca_pkg::mca_cfg_s yc;

  // reference adjust; both bounds checked whatever the length
  function automatic logic [16:0] adj(mca_pkg::mca_cfg_s c, mca_pkg::mca_req_s r, bit wo);
    logic [15:0] p;
    logic [16:0] len;
    logic [16:0] sum;
    logic        hit;
    logic        up;
    logic        dn;
    p   = wo ? {r.ptr[15:1], 1'b0} : r.ptr;
    len = {1'b0, c.stop} - {1'b0, c.start} + 17'h00001;
    sum = {1'b0, p} + {1'b0, r.step};
    hit = c.en && c.sel != mca_pkg::SEL_OFF && r.wreg == c.sel;
    up  = hit && !r.step[15] && r.step != 16'h0000 && p <= c.stop;
    up  = up && (sum[16] || sum[15:0] > c.stop);
    dn  = hit && r.step[15] && p >= c.start && (!sum[16] || sum[15:0] < c.start);
    if (up) return {1'b1, sum[15:0] - len[15:0]};
    if (dn) return {1'b1, sum[15:0] + len[15:0]};
    return {1'b0, sum[15:0]};
  endfunction

  assign wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_ACK_OUT;
  // byte lanes 0 and 1 only; lanes 2 and 3 never reach a register
  always_comb begin
    sh_nxt = sh_r;
    if (wr && WB_ADR_IN[7:2] < 6'h05) begin
      if (WB_SEL_IN[0]) sh_nxt[WB_ADR_IN[4:2]][7:0] = WB_DAT_IN[7:0];
      if (WB_SEL_IN[1]) sh_nxt[WB_ADR_IN[4:2]][15:8] = WB_DAT_IN[15:8];
    end
  end
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) sh_r <= '{0: mca_pkg::RST_CTRL, default: mca_pkg::RST_ADDR};
    else sh_r <= sh_nxt;
  end
  // buffer configuration as the adjust paths should see it
  always_comb begin
    xc = '{en: sh_r[0][mca_pkg::XEN_BIT], sel: sh_r[0][3:0], start: sh_r[1], stop: sh_r[2]};
    yc = '{en: sh_r[0][mca_pkg::YEN_BIT], sel: sh_r[0][7:4], start: sh_r[3], stop: sh_r[4]};
  end
  assign x_act = xc.en && xc.sel != mca_pkg::SEL_OFF;
  assign y_act = yc.en && yc.sel != mca_pkg::SEL_OFF;

  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  sequence s_bus_req;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  endsequence
  sequence s_ack_pulse;
    WB_ACK_OUT ##1 !WB_ACK_OUT;
  endsequence

  a_ack_answer: assert property (s_bus_req |=> s_ack_pulse)
    else $error("bus request not answered by a single ack");
  a_dat_idle: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h00000000)
    else $error("read data not zero outside ack");
  a_reg_readback: assert property (WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN[7:2] < 6'h05
    |-> WB_DAT_OUT[15:0] == sh_r[WB_ADR_IN[4:2]]) else $error("register read mismatch");
  a_x_active_map: assert property ($stable(x_act) |-> X_ACTIVE_OUT == x_act)
    else $error("x active flag mismatch");
  a_y_active_map: assert property ($stable(y_act) |-> Y_ACTIVE_OUT == y_act)
    else $error("y active flag mismatch");
  a_xrd_adjust: assert property (XRD_REQ_IN.valid |=> XRD_RSP_OUT.valid
    && {XRD_RSP_OUT.wrapped, XRD_RSP_OUT.ptr} == $past(adj(xc, XRD_REQ_IN, 1'b0))
    && XRD_RSP_OUT.pspace == $past(XRD_REQ_IN.pspace)) else $error("x read pointer mismatch");
  a_xwr_adjust: assert property (XWR_REQ_IN.valid |=> XWR_RSP_OUT.valid
    && {XWR_RSP_OUT.wrapped, XWR_RSP_OUT.ptr} == $past(adj(xc, XWR_REQ_IN, 1'b0))
    && XWR_RSP_OUT.wreg == $past(XWR_REQ_IN.wreg)) else $error("x write pointer mismatch");
  a_y_adjust: assert property (Y_REQ_IN.valid |=> Y_RSP_OUT.valid
    && {Y_RSP_OUT.wrapped, Y_RSP_OUT.ptr} == $past(adj(yc, Y_REQ_IN, 1'b1)))
    else $error("y pointer mismatch");
  a_y_word_lsb: assert property (Y_REQ_IN.valid ##1 !Y_RSP_OUT.wrapped
    |-> Y_RSP_OUT.ptr[0] == $past(Y_REQ_IN.step[0])) else $error("y address lsb not clear");
  a_rsp_idle: assert property (!Y_REQ_IN.valid |=> !Y_RSP_OUT.valid)
    else $error("y response without request");
endmodule

bind mca_top mca_sva i_sva (.CLK_IN, .RST_B_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN,
  .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT, .XRD_REQ_IN, .XWR_REQ_IN,
  .Y_REQ_IN, .XRD_RSP_OUT, .XWR_RSP_OUT, .Y_RSP_OUT, .X_ACTIVE_OUT, .Y_ACTIVE_OUT);

// ==== tb/mca_agu.sv ====
// execution side model: issues pointer updates and collects adjusted pointers
module mca_agu (
  input  wire logic         clk_in,
  output mca_pkg::mca_req_s req_out [3],
  input  mca_pkg::mca_rsp_s rsp_in  [3]
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // one update per call: 0 x read, 1 x write, 2 y
  // ************************************************************
  initial begin
    foreach (req_out[i]) req_out[i] = '0;
  end
  task automatic shot(input int ch, input logic ps, input logic [3:0] w,
                      input mca_pkg::mca_word_t p, input mca_pkg::mca_word_t s,
                      output mca_pkg::mca_rsp_s r);
    @(posedge clk_in);
    req_out[ch] <= '{1'b1, ps, w, p, s};
    @(posedge clk_in);
    // idle lines carry junk, never a copy of the last request
    req_out[ch] <= '{1'b0, ~ps, ~w, ~p, ~s};
    @(negedge clk_in);
    r = rsp_in[ch];
  endtask
endmodule

// ==== tb/tb.sv ====
// testbench: register access and pointer adjust scenarios
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic [7:0]        adr = 8'h00;
  logic [3:0]        sel = 4'h0;
  logic [31:0]       wdat = 32'h00000000;
  logic [31:0]       rdat;
  logic              ack;
  logic              xact;
  logic              yact;
  logic [31:0]       q;
  mca_pkg::mca_req_s req [3];
  mca_pkg::mca_rsp_s rsp [3];
  int                error_cnt = 0;
  int                n_checks = 0;
  int                cyc_cnt = 0;
  logic [15:0]       rv [8] = '{0: 16'h00FF, default: 16'h0000};
  logic [15:0]       cv [6] = '{16'h8003, 16'h800F, 16'h0003, 16'h4050, 16'h40F0, 16'hC0A7};
  logic [1:0]        av [6] = '{2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h3};

  always #5 clk = ~clk;

  mca_top i_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .XRD_REQ_IN(req[0]), .XWR_REQ_IN(req[1]), .Y_REQ_IN(req[2]),
    .XRD_RSP_OUT(rsp[0]), .XWR_RSP_OUT(rsp[1]), .Y_RSP_OUT(rsp[2]), .X_ACTIVE_OUT(xact),
    .Y_ACTIVE_OUT(yact));
  mca_agu i_agu (.clk_in(clk), .req_out(req), .rsp_in(rsp));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // classic cycle held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {16'hFFFF, d};
    // no answer time assumed; only the run's timeout ends a hang
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 4'hF, 16'h0000);
    chk(n, {16'h0000, e}, {16'h0000, q[15:0]});
  endtask
  task automatic pc(input string n, input int ch, input logic ps, input logic [3:0] w,
                    input logic [15:0] p, input logic [15:0] s, input logic [16:0] e);
    mca_pkg::mca_rsp_s r;
    i_agu.shot(ch, ps, w, p, s, r);
    chk(n, {13'h0, 1'b1, ps, e}, {13'h0, r.valid, r.pspace, r.wrapped, r.ptr});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch and closes the run
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 4000) begin
      error_cnt++;
      results();
    end
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rv[i]) rdc("reset value", 8'(4 * i), rv[i]);
    for (int i = 1; i < 5; i++) begin
      wb(1'b1, 8'(4 * i), 4'hF, 16'hA5C0 + 16'(i));
      rdc("address reg", 8'(4 * i), 16'hA5C0 + 16'(i));
    end
    wb(1'b1, 8'h04, 4'h2, 16'h3C3C);
    rdc("upper lane only", 8'h04, 16'h3CC1);
    wb(1'b1, 8'h1C, 4'hF, 16'hFFFF);
    rdc("unmapped word", 8'h1C, 16'h0000);
    foreach (cv[i]) begin
      wb(1'b1, mca_pkg::OFS_CTRL, 4'hF, cv[i]);
      repeat (2) @(posedge clk);
      chk("active flags", 32'(av[i]), {30'h0, xact, yact});
    end
    // power-of-two x buffer, walked both ways
    wb(1'b1, mca_pkg::OFS_XSTART, 4'hF, 16'h0800);
    wb(1'b1, mca_pkg::OFS_XEND, 4'hF, 16'h081F);
    wb(1'b1, mca_pkg::OFS_CTRL, 4'hF, 16'h80F3);
    pc("x read up wrap", 0, 1'b1, 4'h3, 16'h081E, 16'h0002, 17'h10800);
    pc("x write up", 1, 1'b0, 4'h3, 16'h081C, 16'h0002, 17'h0081E);
    pc("x write down wrap", 1, 1'b0, 4'h3, 16'h0800, 16'hFFFE, 17'h1081E);
    pc("x other reg", 0, 1'b0, 4'h4, 16'h081E, 16'h0002, 17'h00820);
    pc("x no move", 0, 1'b0, 4'h3, 16'h0810, 16'h0000, 17'h00810);
    // working registers 0 to 13 are each chosen as the pointer in turn
    for (int s = 0; s < 14; s++) begin
      wb(1'b1, mca_pkg::OFS_CTRL, 4'hF, 16'h80F0 | 16'(s));
      pc("x any reg", 0, 1'b0, 4'(s), 16'h081E, 16'h0002, 17'h10800);
    end
    wb(1'b1, mca_pkg::OFS_CTRL, 4'hF, 16'h00F3);
    pc("x disabled", 0, 1'b0, 4'h3, 16'h081E, 16'h0002, 17'h00820);
    wb(1'b1, mca_pkg::OFS_CTRL, 4'hF, 16'h80FF);
    pc("x select off", 1, 1'b0, 4'hF, 16'h081E, 16'h0002, 17'h00820);
    // y buffer beside an active x buffer, lengths kept power of two
    wb(1'b1, mca_pkg::OFS_YSTART, 4'hF, 16'h1000);
    wb(1'b1, mca_pkg::OFS_YEND, 4'hF, 16'h100F);
    wb(1'b1, mca_pkg::OFS_CTRL, 4'hF, 16'hC053);
    pc("y up wrap", 2, 1'b0, 4'h5, 16'h100F, 16'h0002, 17'h11000);
    pc("y down wrap", 2, 1'b0, 4'h5, 16'h1001, 16'hFFFE, 17'h1100E);
    pc("x beside y", 0, 1'b0, 4'h3, 16'h081E, 16'h0002, 17'h10800);
    wb(1'b1, mca_pkg::OFS_CTRL, 4'hF, 16'h805F);
    pc("y disabled", 2, 1'b0, 4'h5, 16'h100F, 16'h0002, 17'h01010);
    // largest span: the whole 64 Kbyte space
    wb(1'b1, mca_pkg::OFS_XSTART, 4'hF, 16'h0000);
    wb(1'b1, mca_pkg::OFS_XEND, 4'hF, 16'hFFFF);
    wb(1'b1, mca_pkg::OFS_CTRL, 4'hF, 16'h80F3);
    pc("full span up", 0, 1'b0, 4'h3, 16'hFFFE, 16'h0002, 17'h10000);
    pc("full span down", 1, 1'b0, 4'h3, 16'h0000, 16'hFFFE, 17'h1FFFE);
    // wrap record: 21 wraps spread over all three channels, x still active
    rdc("wrap status", mca_pkg::OFS_STATUS, 16'h0107);
    rdc("wrap count", mca_pkg::OFS_WRAPCNT, 16'h0015);
    wb(1'b1, mca_pkg::OFS_STATUS, 4'h1, 16'h0005);
    rdc("status w1c", mca_pkg::OFS_STATUS, 16'h0102);
    wb(1'b1, mca_pkg::OFS_WRAPCNT, 4'hF, 16'h0000);
    rdc("count clear", mca_pkg::OFS_WRAPCNT, 16'h0000);
    // second reset in mid-run; ctrl, xend and status are read back at their reset values
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rdc("ctrl after reset", mca_pkg::OFS_CTRL, mca_pkg::RST_CTRL);
    rdc("xend after reset", mca_pkg::OFS_XEND, mca_pkg::RST_ADDR);
    rdc("status after reset", mca_pkg::OFS_STATUS, 16'h0000);
    results();
  end
endmodule
